// file: design/tit_params.svh
// Register offsets, field positions, reset values and timing counts of the interval timer
`ifndef TIT_PARAMS_SVH
`define TIT_PARAMS_SVH

`define TIT_CLK_HZ          125000000
`define TIT_REF0_HZ         2458000
`define TIT_REF1_HZ         1229000
`define TIT_REF2_HZ         153600
`define TIT_REF0_DIV        (`TIT_CLK_HZ / `TIT_REF0_HZ)
`define TIT_REF1_DIV        (`TIT_CLK_HZ / `TIT_REF1_HZ)
`define TIT_REF2_DIV        (`TIT_CLK_HZ / `TIT_REF2_HZ)

`define TIT_OFF_CFG0        8'h00
`define TIT_OFF_CFG1        8'h04
`define TIT_OFF_CFG2        8'h08
`define TIT_OFF_CNT0        8'h10
`define TIT_OFF_CNT1        8'h14
`define TIT_OFF_CNT2        8'h18
`define TIT_OFF_TRIG        8'h20
`define TIT_OFF_STAT        8'h24
`define TIT_OFF_CLR         8'h28
`define TIT_OFF_IEN         8'h2C
`define TIT_OFF_ROUTE       8'h30
`define TIT_OFF_OUTS        8'h34

`define TIT_CFG_MSB         6
`define TIT_ROUTE_PIC_LSB   0
`define TIT_ROUTE_TERM_LSB  2
`define TIT_CLKSEL_EVENT    2'h3

`define TIT_CFG_RST         7'h00
`define TIT_IEN_RST         3'h0
`define TIT_ROUTE_RST       4'h0
`define TIT_CNT_RST         16'h0000
`define TIT_OUT_RST         1'b1

`endif

// file: design/tit_pkg.sv
// Types shared by the interval timer modules
package tit_pkg;

	typedef enum logic [2:0] {
		TIT_TCINT,
		TIT_ONESHOT,
		TIT_RATE,
		TIT_SQUARE,
		TIT_SWSTB,
		TIT_HWSTB,
		TIT_EVENT
	} tit_mode_e;

	typedef struct packed {
		logic       gate_en;
		logic [1:0] clksel;
		logic       bcd;
		tit_mode_e  mode;
	} tit_cfg_s;

	typedef struct packed {
		logic [15:0] count;
		logic [15:0] reload;
		logic        out;
		logic        run;
		logic        strobe;
		logic        gate_q;
		logic        tc;
	} tit_cnt_s;

	typedef struct packed {
		tit_cfg_s [2:0]       cfg;
		logic [2:0]           status;
		logic [2:0]           ien;
		logic [3:0]           route;
		logic [2:0][9:0]      div;
		logic [2:0]           ref_tick;
		logic [2:0]           ev_q;
		logic                 dp_wr;
		logic [7:0]           dp_addr;
		logic [31:0]          rdata;
	} tit_top_s;

endpackage

// file: design/tit_counter.sv
// One 16-bit down counter with its seven functions
`include "tit_params.svh"

module tit_counter
	import tit_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        srst,
	input  tit_cfg_s         cfg,
	input  wire logic        tick,
	input  wire logic        gate,
	input  wire logic        load,
	input  wire logic [15:0] load_val,
	input  wire logic        sw_trig,
	output logic      [15:0] count,
	output logic             out,
	output logic             tc
);

	tit_cnt_s    s;
	tit_cnt_s    n;
	logic [15:0] dec;
	logic [15:0] half;
	logic        trig_mode;
	logic        trig;

	function automatic logic [15:0] tit_dec(input logic [15:0] v, input logic bcd);
		logic [15:0] r;
		logic        borrow;
		r = v - 16'h0001;
		borrow = 1'b1;
		if (bcd) begin
			for (int d = 0; d < 4; d++) begin
				r[d*4 +: 4] = v[d*4 +: 4];
				if (borrow && v[d*4 +: 4] == 4'h0) begin
					r[d*4 +: 4] = 4'h9;
				end else if (borrow) begin
					r[d*4 +: 4] = v[d*4 +: 4] - 4'h1;
					borrow = 1'b0;
				end
			end
		end
		return r;
	endfunction

	// Packed decimal digits compare like binary, so only the halving differs
	function automatic logic [15:0] tit_half(input logic [15:0] v, input logic bcd);
		logic [15:0] r;
		logic        carry;
		r = {1'b0, v[15:1]};
		carry = 1'b0;
		if (bcd) begin
			for (int d = 3; d >= 0; d--) begin
				r[d*4 +: 4] = {1'b0, v[d*4+1 +: 3]} + (carry ? 4'h5 : 4'h0);
				carry = v[d*4];
			end
		end
		return r;
	endfunction

	always_comb begin
		n = s;
		n.tc = 1'b0;
		n.gate_q = gate;
		dec = tit_dec(s.count, cfg.bcd);
		half = tit_half(s.reload, cfg.bcd);
		trig_mode = (cfg.mode == TIT_ONESHOT) || (cfg.mode == TIT_HWSTB);
		trig = (trig_mode && gate && !s.gate_q) || (sw_trig && cfg.mode == TIT_ONESHOT);
		if (load) begin
			n.reload = load_val;
			n.count = load_val;
			n.strobe = 1'b0;
			n.out = !(cfg.mode == TIT_TCINT || cfg.mode == TIT_EVENT);
			n.run = !trig_mode;
		end else if (trig) begin
			// Retrigger restarts the full count
			n.count = s.reload;
			n.run = 1'b1;
			n.strobe = 1'b0;
			n.out = (cfg.mode == TIT_HWSTB);
		end else if (tick && s.run && (gate || trig_mode)) begin
			case (cfg.mode)
				TIT_RATE: begin
					if (s.count == 16'h0001) begin
						n.count = s.reload;
						n.out = 1'b1;
						n.tc = 1'b1;
					end else begin
						n.count = dec;
						n.out = (dec != 16'h0001);
					end
				end
				TIT_SQUARE: begin
					if (s.count == 16'h0001) begin
						n.count = s.reload;
						n.out = 1'b1;
						n.tc = 1'b1;
					end else begin
						n.count = dec;
						n.out = (dec > half);
					end
				end
				TIT_SWSTB, TIT_HWSTB: begin
					if (s.strobe) begin
						n.out = 1'b1;
						n.run = 1'b0;
						n.strobe = 1'b0;
					end else if (s.count == 16'h0001) begin
						n.count = dec;
						n.out = 1'b0;
						n.strobe = 1'b1;
						n.tc = 1'b1;
					end else begin
						n.count = dec;
					end
				end
				default: begin
					if (s.count == 16'h0001) begin
						n.count = dec;
						n.out = 1'b1;
						n.run = 1'b0;
						n.tc = 1'b1;
					end else begin
						n.count = dec;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			s <= '0;
			s.count <= `TIT_CNT_RST;
			s.reload <= `TIT_CNT_RST;
			s.out <= `TIT_OUT_RST;
		end else begin
			s <= n;
		end
	end

	assign count = s.count;
	assign out = s.out;
	assign tc = s.tc;

	default clocking @(posedge mclk); endclocking
	default disable iff (srst);

	logic go;
	assign go = tick && s.run && gate && !load && !trig;

	dec_once_a: assert property (go && cfg.mode == TIT_TCINT && !cfg.bcd && s.count > 16'h0001
		|=> s.count == $past(s.count) - 16'h0001) else $error("count did not step by one");
	bcd_borrow_a: assert property (go && cfg.mode == TIT_TCINT && cfg.bcd && s.count == 16'h0010
		|=> s.count == 16'h0009) else $error("decimal borrow wrong");
	tc_zero_a: assert property (tc && cfg.mode == TIT_TCINT |-> s.count == 16'h0000 && out)
		else $error("terminal count not at zero");
	rate_pulse_a: assert property ($fell(out) && cfg.mode == TIT_RATE |-> s.count == 16'h0001)
		else $error("rate low pulse at wrong count");
	square_start_a: assert property (load && cfg.mode == TIT_SQUARE |=> out)
		else $error("square wave not high after load");
	oneshot_low_a: assert property (trig && !load && cfg.mode == TIT_ONESHOT |=> !out && s.run)
		else $error("one-shot did not start");
	strobe_one_a: assert property ($fell(out) && cfg.mode == TIT_SWSTB |-> s.strobe && tc)
		else $error("strobe without terminal count");
	hw_strobe_a: assert property (trig && !load && cfg.mode == TIT_HWSTB
		|=> out && s.count == $past(s.reload)) else $error("hardware strobe restart wrong");

	rate_wrap_c: cover property (tc && cfg.mode == TIT_RATE);
	square_low_c: cover property ($fell(out) && cfg.mode == TIT_SQUARE);
	retrigger_c: cover property (trig && s.run && cfg.mode == TIT_ONESHOT);

endmodule

// file: design/tit_top.sv
// Three-channel interval timer with AHB-Lite register slave
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`include "tit_params.svh"

module tit_top
	import tit_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic      [31:0] hrdata,
	output logic             hresp,
	input  wire logic [2:0]  gate_in,
	input  wire logic [2:0]  event_in,
	output logic      [2:0]  cnt_out,
	output logic             baud_clk,
	output logic      [1:0]  pic_req,
	output logic      [1:0]  term_out,
	output logic             irq
);

	localparam logic [2:0][9:0] REF_DIV = {10'(`TIT_REF2_DIV), 10'(`TIT_REF1_DIV), 10'(`TIT_REF0_DIV)};

	tit_top_s         s;
	tit_top_s         n;
	logic [2:0]       tick;
	logic [2:0]       gate_eff;
	logic [2:0]       load;
	logic [2:0]       sw_trig;
	logic [2:0]       clr;
	logic [2:0]       tc;
	logic [2:0]       outs;
	logic [2:0][15:0] count;
	logic [31:0]      rd_val;
	logic             addr_hit;
	logic             access;

	assign access = hsel && htrans[1] && hready;
	assign addr_hit = (haddr[31:8] == 24'h00_0000);

	// Read data is latched in the address phase so the data phase has zero wait
	always_comb begin
		rd_val = 32'h0000_0000;
		if (!addr_hit) begin
			rd_val = 32'h0000_0000;
		end else if (haddr[7:0] == `TIT_OFF_CFG0) begin
			rd_val = {25'h000_0000, s.cfg[0]};
		end else if (haddr[7:0] == `TIT_OFF_CFG1) begin
			rd_val = {25'h000_0000, s.cfg[1]};
		end else if (haddr[7:0] == `TIT_OFF_CFG2) begin
			rd_val = {25'h000_0000, s.cfg[2]};
		end else if (haddr[7:0] == `TIT_OFF_CNT0) begin
			rd_val = {16'h0000, count[0]};
		end else if (haddr[7:0] == `TIT_OFF_CNT1) begin
			rd_val = {16'h0000, count[1]};
		end else if (haddr[7:0] == `TIT_OFF_CNT2) begin
			rd_val = {16'h0000, count[2]};
		end else if (haddr[7:0] == `TIT_OFF_STAT) begin
			rd_val = {29'h0000_0000, s.status};
		end else if (haddr[7:0] == `TIT_OFF_IEN) begin
			rd_val = {29'h0000_0000, s.ien};
		end else if (haddr[7:0] == `TIT_OFF_ROUTE) begin
			rd_val = {28'h000_0000, s.route};
		end else if (haddr[7:0] == `TIT_OFF_OUTS) begin
			rd_val = {29'h0000_0000, outs};
		end
	end

	always_comb begin
		n = s;
		load = 3'h0;
		sw_trig = 3'h0;
		clr = 3'h0;
		for (int i = 0; i < 3; i++) begin
			if (s.div[i] == REF_DIV[i] - 10'h001) begin
				n.div[i] = 10'h000;
				n.ref_tick[i] = 1'b1;
			end else begin
				n.div[i] = s.div[i] + 10'h001;
				n.ref_tick[i] = 1'b0;
			end
		end
		n.ev_q = event_in;
		n.dp_wr = access && hwrite && addr_hit;
		if (access) begin
			n.dp_addr = haddr[7:0];
		end
		if (access && !hwrite) begin
			n.rdata = rd_val;
		end
		if (s.dp_wr) begin
			if (s.dp_addr == `TIT_OFF_CFG0) begin
				n.cfg[0] = tit_cfg_s'(hwdata[`TIT_CFG_MSB:0]);
			end else if (s.dp_addr == `TIT_OFF_CFG1) begin
				n.cfg[1] = tit_cfg_s'(hwdata[`TIT_CFG_MSB:0]);
			end else if (s.dp_addr == `TIT_OFF_CFG2) begin
				n.cfg[2] = tit_cfg_s'(hwdata[`TIT_CFG_MSB:0]);
			end else if (s.dp_addr == `TIT_OFF_CNT0) begin
				load[0] = 1'b1;
			end else if (s.dp_addr == `TIT_OFF_CNT1) begin
				load[1] = 1'b1;
			end else if (s.dp_addr == `TIT_OFF_CNT2) begin
				load[2] = 1'b1;
			end else if (s.dp_addr == `TIT_OFF_TRIG) begin
				sw_trig = hwdata[2:0];
			end else if (s.dp_addr == `TIT_OFF_CLR) begin
				clr = hwdata[2:0];
			end else if (s.dp_addr == `TIT_OFF_IEN) begin
				n.ien = hwdata[2:0];
			end else if (s.dp_addr == `TIT_OFF_ROUTE) begin
				n.route = hwdata[3:0];
			end
		end
		// A terminal count in the clear cycle stays flagged
		n.status = (s.status & ~clr) | tc;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			s <= '0;
			s.cfg <= {3{`TIT_CFG_RST}};
			s.ien <= `TIT_IEN_RST;
			s.route <= `TIT_ROUTE_RST;
		end else begin
			s <= n;
		end
	end

	// Event edges beyond half the system clock would be missed; the documented limit is far below
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			if (s.cfg[i].clksel == `TIT_CLKSEL_EVENT) begin
				tick[i] = event_in[i] && !s.ev_q[i];
			end else begin
				tick[i] = s.ref_tick[s.cfg[i].clksel];
			end
			gate_eff[i] = s.cfg[i].gate_en ? gate_in[i] : 1'b1;
		end
	end

	for (genvar g = 0; g < 3; g++) begin : g_cnt
		tit_counter u_cnt (
			.mclk     (mclk),
			.srst     (srst),
			.cfg      (s.cfg[g]),
			.tick     (tick[g]),
			.gate     (gate_eff[g]),
			.load     (load[g]),
			.load_val (hwdata[15:0]),
			.sw_trig  (sw_trig[g]),
			.count    (count[g]),
			.out      (outs[g]),
			.tc       (tc[g])
		);
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s.rdata;
	assign cnt_out = outs;
	assign baud_clk = outs[2];
	assign pic_req = outs[1:0] & s.route[`TIT_ROUTE_PIC_LSB +: 2];
	assign term_out = outs[1:0] & s.route[`TIT_ROUTE_TERM_LSB +: 2];
	assign irq = |(s.status & s.ien);

	default clocking @(posedge mclk); endclocking
	default disable iff (srst);

	status_set_a: assert property (tc[0] |=> s.status[0] ##1 (s.status[0] || $past(clr[0])))
		else $error("terminal count not flagged");
	irq_mask_a: assert property (tc[1] && s.ien[1] |=> irq)
		else $error("enabled event gave no interrupt");
	count_read_a: assert property (access && !hwrite && haddr == {24'h00_0000, `TIT_OFF_CNT0}
		|=> hrdata == {16'h0000, $past(count[0])}) else $error("live count read wrong");
	cfg_write_a: assert property (s.dp_wr && s.dp_addr == `TIT_OFF_CFG0
		|=> s.cfg[0] == $past(hwdata[`TIT_CFG_MSB:0])) else $error("configuration not stored");
	baud_load_a: assert property (s.dp_wr && s.dp_addr == `TIT_OFF_CNT2
		|=> count[2] == $past(hwdata[15:0])) else $error("bit-rate divisor not loaded");
	pic_route_a: assert property ($rose(outs[0]) && s.route[0] |-> pic_req[0] && !term_out[0] == !s.route[2])
		else $error("interrupt routing wrong");
	ref0_rate_a: assert property (s.ref_tick[0] |-> ##50 s.ref_tick[0])
		else $error("fast reference period wrong");
	ref1_rate_a: assert property (s.ref_tick[1] |-> ##101 s.ref_tick[1])
		else $error("middle reference period wrong");

	irq_rise_c: cover property ($rose(irq));
	event_tick_c: cover property (tick[0] && s.cfg[0].clksel == `TIT_CLKSEL_EVENT);

endmodule

// file: verification/tit_host.sv
// Host processor model: AHB-Lite master making single word transfers
module tit_host (
	input  wire logic        mclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
	end

	// Entered just after a rising edge; returns at the edge that closes the data phase
	task automatic xfer(input logic wr, input logic [7:0] off, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, off};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		do @(posedge mclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge mclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
endmodule

// file: verification/tb.sv
// Self-checking bench for the three-channel interval timer
`include "tit_params.svh"

`define CHK(nm, ex, gt) begin \
	num_checks++; \
	if ((gt) !== (ex)) begin \
		fail_count++; \
		$display("mismatch %s expected %0h seen %0h", nm, ex, gt); \
	end \
end

// Outputs are looked at mid-cycle, away from the edge that moves them
`define PIN(nm, ex, gt) begin @(negedge mclk); `CHK(nm, ex, gt) @(posedge mclk); end

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        mclk;
	logic        srst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hready;
	logic [31:0] hrdata;
	logic        hresp;
	logic [2:0]  gate_in;
	logic [2:0]  event_in;
	logic [2:0]  cnt_out;
	logic        baud_clk;
	logic [1:0]  pic_req;
	logic [1:0]  term_out;
	logic        irq;
	logic [31:0] rv;
	logic [7:0]  sq;
	int          fail_count;
	int          num_checks;

	tit_top tit_top_inst (
		.mclk      (mclk),
		.srst      (srst),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hready),
		.hrdata    (hrdata),
		.hresp     (hresp),
		.gate_in   (gate_in),
		.event_in  (event_in),
		.cnt_out   (cnt_out),
		.baud_clk  (baud_clk),
		.pic_req   (pic_req),
		.term_out  (term_out),
		.irq       (irq)
	);

	tit_host tit_host_inst (
		.mclk   (mclk),
		.hready (hready),
		.hrdata (hrdata),
		.hsel   (hsel),
		.haddr  (haddr),
		.htrans (htrans),
		.hwrite (hwrite),
		.hsize  (hsize),
		.hwdata (hwdata)
	);

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Tests need well under 3000 cycles
	initial begin
		repeat (10000) @(posedge mclk);
		fail_count++;
		$display("mismatch timeout expected 0 seen 1");
		wrap_up();
	end

	task automatic wr(input logic [7:0] off, input logic [31:0] d);
		logic [31:0] r;
		tit_host_inst.xfer(1'b1, off, d, r);
		// Write lands at the closing edge; a read taken there would still see the old value
		@(posedge mclk);
	endtask

	task automatic rd(input logic [7:0] off);
		tit_host_inst.xfer(1'b0, off, 32'h0000_0000, rv);
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] off, input logic [31:0] ex);
		rd(off);
		`CHK(nm, ex, rv)
	endtask

	// One event edge, held long enough for the edge detector
	task automatic ev(input int i);
		event_in[i] <= 1'b1;
		repeat (2) @(posedge mclk);
		event_in[i] <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask

	task automatic seq(input string nm, input int i, input logic [7:0] e, input int n);
		for (int k = 0; k < n; k++) begin
			ev(i);
			`PIN(nm, e[k], cnt_out[i])
		end
	endtask

	initial begin
		srst = 1'b1;
		gate_in = 3'h0;
		event_in = 3'h0;
		fail_count = 0;
		num_checks = 0;
		repeat (12) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		rd_chk("outs rst", `TIT_OFF_OUTS, 32'h0000_0007);
		rd_chk("cnt0 rst", `TIT_OFF_CNT0, 32'h0000_0000);
		`CHK("hresp okay", 1'b0, hresp)
		$display("test reset done");

		wr(`TIT_OFF_ROUTE, 32'h0000_0006);
		wr(`TIT_OFF_IEN, 32'h0000_0001);
		wr(`TIT_OFF_CFG0, 32'h0000_0030);
		wr(`TIT_OFF_CNT0, 32'h0000_0003);
		rd_chk("tc out low", `TIT_OFF_OUTS, 32'h0000_0006);
		`PIN("term low", 2'b00, term_out)
		`PIN("pic route", 2'b10, pic_req)
		for (int k = 2; k >= 0; k--) begin
			ev(0);
			rd_chk("tc count", `TIT_OFF_CNT0, 32'(k));
		end
		rd_chk("tc out high", `TIT_OFF_OUTS, 32'h0000_0007);
		rd_chk("tc stat", `TIT_OFF_STAT, 32'h0000_0001);
		`PIN("irq on", 1'b1, irq)
		`PIN("term high", 2'b01, term_out)
		wr(`TIT_OFF_IEN, 32'h0000_0000);
		`PIN("irq masked", 1'b0, irq)
		wr(`TIT_OFF_IEN, 32'h0000_0001);
		`PIN("irq unmasked", 1'b1, irq)
		wr(`TIT_OFF_CLR, 32'h0000_0001);
		rd_chk("stat clr", `TIT_OFF_STAT, 32'h0000_0000);
		`PIN("irq clr", 1'b0, irq)
		rd_chk("clr reads 0", `TIT_OFF_CLR, 32'h0000_0000);
		wr(8'h40, 32'h0000_ffff);
		rd_chk("unmapped", 8'h40, 32'h0000_0000);
		$display("test tcint done");

		wr(`TIT_OFF_CFG1, 32'h0000_0032);
		wr(`TIT_OFF_CNT1, 32'h0000_0003);
		seq("rate", 1, 8'h0d, 5);
		$display("test rate done");

		wr(`TIT_OFF_CFG2, 32'h0000_0033);
		wr(`TIT_OFF_CNT2, 32'h0000_0004);
		for (int k = 0; k < 8; k++) begin
			ev(2);
			@(negedge mclk);
			sq[k] = baud_clk;
			@(posedge mclk);
		end
		`CHK("sq period", sq[3:0], sq[7:4])
		`CHK("sq half", 2, $countones(sq[3:0]))
		`CHK("sq edges", 2, $countones(sq[3:0] ^ {sq[2:0], sq[3]}))
		$display("test square done");

		wr(`TIT_OFF_CFG0, 32'h0000_0034);
		wr(`TIT_OFF_CNT0, 32'h0000_0002);
		seq("sw strobe", 0, 8'h0d, 4);
		$display("test sw strobe done");

		wr(`TIT_OFF_CFG1, 32'h0000_0075);
		wr(`TIT_OFF_CNT1, 32'h0000_0002);
		seq("hw idle", 1, 8'h03, 2);
		gate_in[1] <= 1'b1;
		repeat (3) @(posedge mclk);
		seq("hw strobe", 1, 8'h0d, 4);
		$display("test hw strobe done");

		wr(`TIT_OFF_CFG0, 32'h0000_0031);
		wr(`TIT_OFF_CNT0, 32'h0000_0002);
		seq("os idle", 0, 8'h01, 1);
		wr(`TIT_OFF_TRIG, 32'h0000_0001);
		`PIN("os low", 1'b0, cnt_out[0])
		seq("os", 0, 8'h02, 2);
		wr(`TIT_OFF_TRIG, 32'h0000_0001);
		ev(0);
		wr(`TIT_OFF_TRIG, 32'h0000_0001);
		seq("os retrig", 0, 8'h02, 2);
		$display("test one-shot done");

		wr(`TIT_OFF_CFG2, 32'h0000_003e);
		wr(`TIT_OFF_CNT2, 32'h0000_0010);
		ev(2);
		rd_chk("bcd step", `TIT_OFF_CNT2, 32'h0000_0009);
		wr(`TIT_OFF_CNT2, 32'h0000_0002);
		wr(`TIT_OFF_CLR, 32'h0000_0007);
		ev(2);
		ev(2);
		rd_chk("ev count", `TIT_OFF_CNT2, 32'h0000_0000);
		rd(`TIT_OFF_STAT);
		`CHK("ev stat", 1'b1, rv[2])
		$display("test event done");

		wr(`TIT_OFF_CFG0, 32'h0000_0040);
		wr(`TIT_OFF_CNT0, 32'h0000_0002);
		repeat (150) @(posedge mclk);
		rd_chk("gated hold", `TIT_OFF_CNT0, 32'h0000_0002);
		gate_in[0] <= 1'b1;
		repeat (120) @(posedge mclk);
		rd_chk("ref count", `TIT_OFF_CNT0, 32'h0000_0000);
		$display("test reference done");
		wrap_up();
	end
endmodule
